// File: inc/ucfg_pkg.sv
// Constants shared by the configuration loader and its serial memory reader
package ucfg_pkg;
   // Device clock and serial memory clock
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned EE_SK_HZ = 1_000_000;
   localparam int unsigned EE_HALF_CYC = CLK_HZ / (2 * EE_SK_HZ);
   localparam int unsigned EE_CMD_BITS = 9;
   localparam int unsigned EE_DATA_BITS = 16;
   localparam logic [2:0] EE_READ_CMD = 3'h6;

   // Image word addresses
   localparam logic [5:0] EE_ADDR_HDR = 6'h00;
   localparam logic [5:0] EE_ADDR_MFR = 6'h1A;
   localparam logic [5:0] EE_ADDR_VOL = 6'h2A;
   localparam logic [5:0] EE_ADDR_CTL = 6'h2B;

   // Header word fields
   localparam int unsigned HDR_CFG_VALID_BIT = 3;
   localparam int unsigned HDR_MFR_EN_BIT = 2;

   // Control word fields
   localparam int unsigned CTL_DAC_SHUT_BIT = 8;
   localparam int unsigned CTL_TOTAL_PWR_BIT = 7;
   localparam int unsigned CTL_RSVD_BIT = 6;
   localparam int unsigned CTL_MIC_HPF_BIT = 5;
   localparam int unsigned CTL_ADC_SYNC_BIT = 4;
   localparam int unsigned CTL_MIC_GAIN_BIT = 3;
   localparam int unsigned CTL_TERM_TYPE_BIT = 2;
   localparam int unsigned CTL_HID_BIT = 1;
   localparam int unsigned CTL_WAKEUP_BIT = 0;

   // Built-in defaults
   localparam logic [15:0] CTL_DEFAULT = 16'h0028;
   localparam logic [15:0] VOL_DEFAULT = 16'h0000;

   // Power figures in 2 mA units
   localparam logic [7:0] PWR_100MA = 8'h32;
   localparam logic [7:0] PWR_500MA = 8'hFA;

   // Declared topology counts
   localparam logic [1:0] TOPO_SPK_TERMS = 2'h1;
   localparam logic [1:0] TOPO_SPK_FEAT = 2'h1;
   localparam logic [1:0] TOPO_HS_TERMS = 2'h2;
   localparam logic [1:0] TOPO_HS_FEAT = 2'h2;

   // Register map (byte addresses)
   localparam logic [11:0] REG_STATUS = 12'h000;
   localparam logic [11:0] REG_CONTROL = 12'h004;
   localparam logic [11:0] REG_VOLUME = 12'h008;
   localparam logic [11:0] REG_CTLWORD = 12'h00C;
   localparam logic [11:0] REG_MFRWORD = 12'h010;
   localparam logic [11:0] REG_HEADER = 12'h014;
   localparam int unsigned CONTROL_RELOAD_BIT = 0;
   localparam int unsigned CONTROL_HOLD_BIT = 1;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
endpackage

// File: inc/ucfg_rd_if.sv
// Word read request channel between the loader and the serial memory reader
`timescale 1ns/1ns
interface ucfg_rd_if;
   logic req;
   logic [5:0] addr;
   logic valid;
   logic [15:0] data;
   modport host (output req, output addr, input valid, input data);
   modport reader (input req, input addr, output valid, output data);
endinterface

// File: rtl/ucfg_ee_reader.sv
// Serial configuration memory word reader, three-wire read command
`timescale 1ns/1ns
module ucfg_ee_reader
   import ucfg_pkg::*;
#(
   parameter int unsigned HALF_CYC = EE_HALF_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   ucfg_rd_if.reader rd,
   output logic eeprom_cs,
   output logic eeprom_sk,
   output logic eeprom_di,
   input wire logic eeprom_do
);
   import ucfg_pkg::*;
   logic [7:0] div_ff;
   logic tick;
   logic cs_ff, sk_ff, di_ff, valid_ff;
   logic [4:0] cnt_ff;
   logic [8:0] cmd_ff;
   logic [15:0] data_ff;

   assign tick = (div_ff == 8'(HALF_CYC - 1));
   assign eeprom_cs = cs_ff;
   assign eeprom_sk = sk_ff;
   assign eeprom_di = di_ff;
   assign rd.valid = valid_ff;
   assign rd.data = data_ff;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         div_ff <= 8'h00;
      end else if (!cs_ff || tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command out on the low phase, data sampled before each falling edge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cs_ff <= 1'b0;
         sk_ff <= 1'b0;
         di_ff <= 1'b0;
         cnt_ff <= 5'h00;
         cmd_ff <= 9'h000;
         data_ff <= 16'h0000;
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= 1'b0;
         if (!cs_ff) begin
            if (rd.req) begin
               cs_ff <= 1'b1;
               cnt_ff <= 5'h00;
               di_ff <= EE_READ_CMD[2];
               cmd_ff <= {EE_READ_CMD[1:0], rd.addr, 1'b0};
            end
         end else if (tick) begin
            if (!sk_ff) begin
               sk_ff <= 1'b1;
            end else begin
               sk_ff <= 1'b0;
               di_ff <= cmd_ff[8];
               cmd_ff <= {cmd_ff[7:0], 1'b0};
               // First bit after the address is the dummy zero
               if (cnt_ff > 5'(EE_CMD_BITS)) begin
                  data_ff <= {data_ff[14:0], eeprom_do};
               end
               if (cnt_ff == 5'(EE_CMD_BITS + EE_DATA_BITS)) begin
                  cs_ff <= 1'b0;
                  di_ff <= 1'b0;
                  valid_ff <= 1'b1;
               end
               cnt_ff <= cnt_ff + 5'h01;
            end
         end
      end
   end

   cs_frame_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(cs_ff) |-> !valid_ff [*8])
      else $error("reader answered too early after selecting the memory");
endmodule // ucfg_ee_reader

// File: rtl/ucfg_loader.sv
// Strap and serial image configuration loader of the audio controller
//
// Overview of operation
// - Mode strap high selects playback-only speaker mode
// - Speaker mode ignores mixer strap, minimal topology
// - Mode strap low selects full-duplex headset mode
// - Headset mode adds mixer and feature per strap
// - Power strap and mode pick power configuration
// - Volume word high byte playback, low record
// - Control bit 8 shuts down playback analog
// - Control bit 7 enables total power control
// - Control bit 5 enables microphone high-pass filter
// - Control bit 4 enables record sync mode
// - Control bit 3 enables microphone gain stage
// - Control bit 2 picks playback terminal type
// - Manufacturer word: length low, first char high
// - Header bit 3 validates volume and control words, else defaults
`timescale 1ns/1ns
module ucfg_loader
   import ucfg_pkg::*;
#(
   parameter int unsigned HALF_CYC = EE_HALF_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic mode_strap,
   input wire logic mixer_select_strap,
   input wire logic power_select_strap,
   output logic eeprom_cs,
   output logic eeprom_sk,
   output logic eeprom_di,
   input wire logic eeprom_do,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic bus_connect,
   output logic config_done,
   output logic speaker_mode,
   output logic record_enable,
   output logic [1:0] topo_input_terms,
   output logic [1:0] topo_output_terms,
   output logic [1:0] topo_feature_units,
   output logic topo_mixer_unit,
   output logic self_powered,
   output logic [7:0] max_power_units,
   output logic [7:0] play_volume,
   output logic [7:0] rec_volume,
   output logic dac_shutdown,
   output logic total_power_ctl,
   output logic mic_highpass_en,
   output logic adc_sync_en,
   output logic microphone_gain_stage,
   output logic headphone_terminal_type,
   output logic hid_enable,
   output logic remote_wakeup_en,
   output logic mfr_string_en,
   output logic [7:0] mfr_string_len,
   output logic [7:0] mfr_first_char
);
   import ucfg_pkg::*;

   typedef enum logic [6:0] {
      ST_STRAP = 7'b000_0001,
      ST_HDR = 7'b000_0010,
      ST_MFR = 7'b000_0100,
      ST_VOL = 7'b000_1000,
      ST_CTL = 7'b001_0000,
      ST_APPLY = 7'b010_0000,
      ST_DONE = 7'b100_0000
   } ucfg_state_t;

   ucfg_state_t state_ff, nxt_state;
   logic mode_ff, mixer_ff, power_ff;
   logic wait_ff, req_ff;
   logic [5:0] addr_ff;
   logic [15:0] hdr_ff, mfr_ff, vol_raw_ff, vol_word_ff, ctl_word_ff;
   logic [1:0] control_ff;
   logic reload;
   logic apb_wr, apb_rd_ok;
   logic [31:0] rd_mux;

   ucfg_rd_if rd_bus ();

   ucfg_ee_reader #(
      .HALF_CYC(HALF_CYC)
   ) u_reader (
      .clock(clock),
      .nrst(nrst),
      .rd(rd_bus.reader),
      .eeprom_cs(eeprom_cs),
      .eeprom_sk(eeprom_sk),
      .eeprom_di(eeprom_di),
      .eeprom_do(eeprom_do)
   );

   assign rd_bus.req = req_ff;
   assign rd_bus.addr = addr_ff;

   function automatic logic [5:0] state_addr(input ucfg_state_t st);
      case (st)
         ST_MFR: state_addr = EE_ADDR_MFR;
         ST_VOL: state_addr = EE_ADDR_VOL;
         ST_CTL: state_addr = EE_ADDR_CTL;
         default: state_addr = EE_ADDR_HDR;
      endcase
   endfunction

   function automatic logic is_read_state(input ucfg_state_t st);
      is_read_state = (st == ST_HDR) || (st == ST_MFR) || (st == ST_VOL) || (st == ST_CTL);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Load sequence
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_STRAP: nxt_state = ST_HDR;
         ST_HDR: if (rd_bus.valid) nxt_state = ST_MFR;
         ST_MFR: if (rd_bus.valid) nxt_state = ST_VOL;
         ST_VOL: if (rd_bus.valid) nxt_state = ST_CTL;
         ST_CTL: if (rd_bus.valid) nxt_state = ST_APPLY;
         ST_APPLY: nxt_state = ST_DONE;
         ST_DONE: if (reload) nxt_state = ST_STRAP;
         default: nxt_state = ST_STRAP;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_STRAP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Straps are caught after reset release, never by the reset itself
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mode_ff <= 1'b0;
         mixer_ff <= 1'b0;
         power_ff <= 1'b0;
      end else if (state_ff == ST_STRAP) begin
         mode_ff <= mode_strap;
         mixer_ff <= mixer_select_strap;
         power_ff <= power_select_strap;
      end
   end

   // One request per word, then wait for the answer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         req_ff <= 1'b0;
         wait_ff <= 1'b0;
         addr_ff <= EE_ADDR_HDR;
      end else begin
         req_ff <= 1'b0;
         if (is_read_state(state_ff) && !wait_ff) begin
            req_ff <= 1'b1;
            wait_ff <= 1'b1;
            addr_ff <= state_addr(state_ff);
         end else if (rd_bus.valid) begin
            wait_ff <= 1'b0;
         end
      end
   end

   // Raw image words; defaults replace volume and control unless validated
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hdr_ff <= 16'h0000;
         mfr_ff <= 16'h0000;
         vol_raw_ff <= VOL_DEFAULT;
         vol_word_ff <= VOL_DEFAULT;
         ctl_word_ff <= CTL_DEFAULT;
      end else if (rd_bus.valid) begin
         case (state_ff)
            ST_HDR: hdr_ff <= rd_bus.data;
            ST_MFR: mfr_ff <= rd_bus.data;
            ST_VOL: vol_raw_ff <= rd_bus.data;
            ST_CTL: begin
               // Reserved bit 6 is used as written; image must hold it at zero
               vol_word_ff <= hdr_ff[HDR_CFG_VALID_BIT] ? vol_raw_ff : VOL_DEFAULT;
               ctl_word_ff <= hdr_ff[HDR_CFG_VALID_BIT] ? rd_bus.data : CTL_DEFAULT;
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs toward descriptor, topology and analog logic
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         speaker_mode <= 1'b0;
         record_enable <= 1'b0;
         topo_input_terms <= 2'h0;
         topo_output_terms <= 2'h0;
         topo_feature_units <= 2'h0;
         topo_mixer_unit <= 1'b0;
         self_powered <= 1'b0;
         max_power_units <= 8'h00;
      end else if (state_ff == ST_APPLY) begin
         speaker_mode <= mode_ff;
         record_enable <= ~mode_ff;
         if (mode_ff) begin
            topo_input_terms <= TOPO_SPK_TERMS;
            topo_output_terms <= TOPO_SPK_TERMS;
            topo_feature_units <= TOPO_SPK_FEAT;
            topo_mixer_unit <= 1'b0;
         end else begin
            topo_input_terms <= TOPO_HS_TERMS;
            topo_output_terms <= TOPO_HS_TERMS;
            topo_feature_units <= TOPO_HS_FEAT + {1'b0, mixer_ff};
            topo_mixer_unit <= mixer_ff;
         end
         self_powered <= power_ff & mode_ff;
         max_power_units <= power_ff ? PWR_100MA : PWR_500MA;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         play_volume <= VOL_DEFAULT[15:8];
         rec_volume <= VOL_DEFAULT[7:0];
         dac_shutdown <= CTL_DEFAULT[CTL_DAC_SHUT_BIT];
         total_power_ctl <= CTL_DEFAULT[CTL_TOTAL_PWR_BIT];
         mic_highpass_en <= CTL_DEFAULT[CTL_MIC_HPF_BIT];
         adc_sync_en <= CTL_DEFAULT[CTL_ADC_SYNC_BIT];
         microphone_gain_stage <= CTL_DEFAULT[CTL_MIC_GAIN_BIT];
         headphone_terminal_type <= CTL_DEFAULT[CTL_TERM_TYPE_BIT];
         hid_enable <= CTL_DEFAULT[CTL_HID_BIT];
         remote_wakeup_en <= CTL_DEFAULT[CTL_WAKEUP_BIT];
         mfr_string_en <= 1'b0;
         mfr_string_len <= 8'h00;
         mfr_first_char <= 8'h00;
      end else if (state_ff == ST_APPLY) begin
         play_volume <= vol_word_ff[15:8];
         rec_volume <= vol_word_ff[7:0];
         dac_shutdown <= ctl_word_ff[CTL_DAC_SHUT_BIT];
         total_power_ctl <= ctl_word_ff[CTL_TOTAL_PWR_BIT];
         mic_highpass_en <= ctl_word_ff[CTL_MIC_HPF_BIT];
         adc_sync_en <= ctl_word_ff[CTL_ADC_SYNC_BIT];
         microphone_gain_stage <= ctl_word_ff[CTL_MIC_GAIN_BIT];
         headphone_terminal_type <= ctl_word_ff[CTL_TERM_TYPE_BIT];
         hid_enable <= ctl_word_ff[CTL_HID_BIT];
         remote_wakeup_en <= ctl_word_ff[CTL_WAKEUP_BIT];
         mfr_string_en <= hdr_ff[HDR_MFR_EN_BIT];
         mfr_string_len <= mfr_ff[7:0];
         mfr_first_char <= mfr_ff[15:8];
      end
   end

   // Connect only once everything is applied; a reload disconnects too
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         config_done <= 1'b0;
         bus_connect <= 1'b0;
      end else begin
         config_done <= (state_ff == ST_APPLY) || (config_done && state_ff == ST_DONE);
         bus_connect <= config_done && state_ff == ST_DONE && !reload && !control_ff[CONTROL_HOLD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state on every access
   assign apb_wr = psel && penable && pwrite && !pready;
   assign reload = apb_wr && paddr == REG_CONTROL && pwdata[CONTROL_RELOAD_BIT];

   always_comb begin
      apb_rd_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         REG_STATUS: rd_mux = {25'h000_0000, mode_ff, mixer_ff, power_ff, hdr_ff[HDR_CFG_VALID_BIT],
                               bus_connect, config_done, state_ff != ST_DONE};
         REG_CONTROL: rd_mux = {30'h0000_0000, control_ff};
         REG_VOLUME: rd_mux = {16'h0000, vol_word_ff};
         REG_CTLWORD: rd_mux = {16'h0000, ctl_word_ff};
         REG_MFRWORD: rd_mux = {16'h0000, mfr_ff};
         REG_HEADER: rd_mux = {16'h0000, hdr_ff};
         default: apb_rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !apb_rd_ok;
         prdata <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         control_ff <= CONTROL_RESET;
      end else if (apb_wr && paddr == REG_CONTROL) begin
         // Reload bit is a command and never stays set
         control_ff[CONTROL_HOLD_BIT] <= pwdata[CONTROL_HOLD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   spk_playback_a: assert property (@(posedge clock) disable iff (!nrst)
      config_done && speaker_mode |-> !record_enable && self_powered == power_ff)
      else $error("speaker mode declared a record function");
   spk_topology_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(config_done) && mode_ff |-> topo_input_terms == 2'h1 && topo_output_terms == 2'h1
      && topo_feature_units == 2'h1 && !topo_mixer_unit)
      else $error("speaker topology wrong");
   hs_duplex_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(config_done) && !mode_ff |-> record_enable && !speaker_mode)
      else $error("headset mode lacks recording");
   hs_mixer_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(config_done) && !mode_ff |-> topo_mixer_unit == mixer_ff
      && topo_feature_units == 2'(2 + mixer_ff))
      else $error("mixer strap not reflected");
   power_cfg_a: assert property (@(posedge clock) disable iff (!nrst)
      config_done |-> max_power_units == (power_ff ? 8'h32 : 8'hFA))
      else $error("power configuration wrong");
   vol_split_a: assert property (@(posedge clock) disable iff (!nrst)
      config_done |-> {play_volume, rec_volume} == vol_word_ff)
      else $error("volume bytes misplaced");
   ctl_bits_a: assert property (@(posedge clock) disable iff (!nrst)
      config_done |-> dac_shutdown == ctl_word_ff[8] && total_power_ctl == ctl_word_ff[7]
      && mic_highpass_en == ctl_word_ff[5] && adc_sync_en == ctl_word_ff[4]
      && microphone_gain_stage == ctl_word_ff[3] && headphone_terminal_type == ctl_word_ff[2])
      else $error("control bits misapplied");
   mfr_word_a: assert property (@(posedge clock) disable iff (!nrst)
      config_done |-> {mfr_first_char, mfr_string_len} == mfr_ff)
      else $error("manufacturer word misplaced");
   cfg_default_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(config_done) && !hdr_ff[3] |-> ctl_word_ff == 16'h0028 && vol_word_ff == 16'h0000)
      else $error("invalid image not replaced by defaults");
   connect_late_a: assert property (@(posedge clock) disable iff (!nrst)
      bus_connect |-> $past(config_done) && state_ff == ST_DONE)
      else $error("connected before configuration complete");

   load_spk_c: cover property (@(posedge clock) disable iff (!nrst) $rose(config_done) && speaker_mode);
   load_hs_c: cover property (@(posedge clock) disable iff (!nrst) $rose(config_done) && topo_mixer_unit);
   reload_c: cover property (@(posedge clock) disable iff (!nrst) reload ##[1:1000] $fell(config_done));
endmodule // ucfg_loader

// File: bench/ucfg_ee_model.sv
// Behavioural model of the serial configuration memory, word read only
`timescale 1ns/1ns
module ucfg_ee_model (
   input wire logic eeprom_cs,
   input wire logic eeprom_sk,
   input wire logic eeprom_di,
   output logic eeprom_do
);
   logic [15:0] mem [64];
   logic [8:0] cmd_ff;
   int cnt;
   initial begin
      // Blank image so the load after power-up reads defined words
      foreach (mem[i]) mem[i] = 16'h0000;
      eeprom_do = 1'b0;
      cmd_ff = '0;
      cnt = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge eeprom_cs) begin
      cnt = 0;
   end
   // Released line shows the inverse of its last bit, never a stale level
   always @(negedge eeprom_cs) begin
      eeprom_do <= ~eeprom_do;
   end
   always @(posedge eeprom_sk) begin
      if (eeprom_cs) begin
         cnt = cnt + 1;
         if (cnt <= 9) begin
            cmd_ff = {cmd_ff[7:0], eeprom_di};
         end
         if (cnt == 10) begin
            eeprom_do <= 1'b0;
         end else if (cnt > 10 && cnt <= 26) begin
            // Bad command start bits give garbage, as a real part would
            eeprom_do <= (cmd_ff[8:6] == 3'b110) ? mem[cmd_ff[5:0]][26 - cnt] : ~eeprom_do;
         end
      end
   end
endmodule // ucfg_ee_model

// File: bench/tb_top.sv
// Self-checking bench of the configuration loader
`timescale 1ns/1ns
module tb_top;
   import ucfg_pkg::*;
   typedef struct packed {
      logic mode;
      logic mix;
      logic pwr;
      logic [15:0] hdr;
      logic [15:0] vol;
      logic [15:0] ctl;
      logic [15:0] mfr;
   } ucfg_row_t;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic mode_strap = 1'b1, mixer_select_strap = 1'b0, power_select_strap = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, eeprom_cs, eeprom_sk, eeprom_di, eeprom_do;
   logic bus_connect, config_done, speaker_mode, record_enable, topo_mixer_unit, self_powered;
   logic [1:0] topo_input_terms, topo_output_terms, topo_feature_units;
   logic [7:0] max_power_units, play_volume, rec_volume, mfr_string_len, mfr_first_char;
   logic dac_shutdown, total_power_ctl, mic_highpass_en, adc_sync_en, microphone_gain_stage;
   logic headphone_terminal_type, hid_enable, remote_wakeup_en, mfr_string_en;
   int n_errors = 0;
   int total_checks = 0;
   logic [15:0] ev, ec;
   // Control values all keep the reserved bit 6 clear
   ucfg_row_t rows [8] = '{
      '{1'b1, 1'b0, 1'b1, 16'h0008, 16'hA55A, 16'h0100, 16'h4310},
      '{1'b1, 1'b1, 1'b0, 16'h000C, 16'h1234, 16'h0080, 16'h4A22},
      '{1'b0, 1'b0, 1'b1, 16'h000C, 16'h80FF, 16'h0020, 16'h0004},
      '{1'b0, 1'b1, 1'b1, 16'h0008, 16'h7F01, 16'h0010, 16'hFFFF},
      '{1'b0, 1'b0, 1'b0, 16'h000C, 16'h0102, 16'h0008, 16'h5A3C},
      '{1'b0, 1'b1, 1'b0, 16'h000C, 16'hFE80, 16'h0004, 16'h0102},
      '{1'b1, 1'b0, 1'b0, 16'h0004, 16'hABCD, 16'h01BF, 16'h8001},
      '{1'b1, 1'b1, 1'b1, 16'h000F, 16'hFFFF, 16'h01BF, 16'h2E18}};
   ucfg_loader #(.HALF_CYC(1)) dut (.clock(clock), .nrst(nrst), .mode_strap(mode_strap),
      .mixer_select_strap(mixer_select_strap), .power_select_strap(power_select_strap),
      .eeprom_cs(eeprom_cs), .eeprom_sk(eeprom_sk), .eeprom_di(eeprom_di), .eeprom_do(eeprom_do),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_connect(bus_connect), .config_done(config_done),
      .speaker_mode(speaker_mode), .record_enable(record_enable), .topo_input_terms(topo_input_terms),
      .topo_output_terms(topo_output_terms), .topo_feature_units(topo_feature_units),
      .topo_mixer_unit(topo_mixer_unit), .self_powered(self_powered), .max_power_units(max_power_units),
      .play_volume(play_volume), .rec_volume(rec_volume), .dac_shutdown(dac_shutdown),
      .total_power_ctl(total_power_ctl), .mic_highpass_en(mic_highpass_en), .adc_sync_en(adc_sync_en),
      .microphone_gain_stage(microphone_gain_stage), .headphone_terminal_type(headphone_terminal_type),
      .hid_enable(hid_enable), .remote_wakeup_en(remote_wakeup_en), .mfr_string_en(mfr_string_en),
      .mfr_string_len(mfr_string_len), .mfr_first_char(mfr_first_char));
   ucfg_ee_model ee (.eeprom_cs(eeprom_cs), .eeprom_sk(eeprom_sk), .eeprom_di(eeprom_di),
      .eeprom_do(eeprom_do));
   always #25 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Request held from setup until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_load;
      int n;
      n = 0;
      while (config_done === 1'b1 && n < 40) begin
         @(posedge clock);
         n++;
      end
      n = 0;
      while (config_done !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
         check({31'h0, bus_connect}, 32'h0);
      end
      if (n >= 3000) n_errors++;
      repeat (2) @(posedge clock);
      check({31'h0, bus_connect}, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(50 * 20000);
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge clock);
      check({dac_shutdown, mic_highpass_en, microphone_gain_stage, config_done, bus_connect}, 32'h0C);
      nrst <= 1'b1;
      wait_load();
      foreach (rows[i]) begin
         ee.mem[EE_ADDR_HDR] = rows[i].hdr;
         ee.mem[EE_ADDR_MFR] = rows[i].mfr;
         ee.mem[EE_ADDR_VOL] = rows[i].vol;
         ee.mem[EE_ADDR_CTL] = rows[i].ctl;
         mode_strap <= rows[i].mode;
         mixer_select_strap <= rows[i].mix;
         power_select_strap <= rows[i].pwr;
         apb(1'b1, REG_CONTROL, 32'h0000_0001);
         wait_load();
         ev = rows[i].hdr[3] ? rows[i].vol : VOL_DEFAULT;
         ec = rows[i].hdr[3] ? rows[i].ctl : CTL_DEFAULT;
         check({speaker_mode, record_enable}, {rows[i].mode, !rows[i].mode});
         check({topo_input_terms, topo_output_terms, topo_feature_units, topo_mixer_unit},
            rows[i].mode ? {TOPO_SPK_TERMS, TOPO_SPK_TERMS, TOPO_SPK_FEAT, 1'b0} : {TOPO_HS_TERMS,
            TOPO_HS_TERMS, TOPO_HS_FEAT + {1'b0, rows[i].mix}, rows[i].mix});
         check({self_powered, max_power_units}, {rows[i].mode & rows[i].pwr,
            rows[i].pwr ? PWR_100MA : PWR_500MA});
         check({play_volume, rec_volume}, ev);
         check({dac_shutdown, total_power_ctl, mic_highpass_en, adc_sync_en, microphone_gain_stage,
            headphone_terminal_type}, {ec[8:7], ec[5:2]});
         check({hid_enable, remote_wakeup_en}, ec[1:0]);
         check({mfr_string_en, mfr_first_char, mfr_string_len}, {rows[i].hdr[2], rows[i].mfr});
         apb(1'b0, REG_VOLUME, 32'h0000_0000);
         check(rd, {16'h0000, ev});
         apb(1'b0, REG_CTLWORD, 32'h0000_0000);
         check(rd, {16'h0000, ec});
         apb(1'b0, REG_MFRWORD, 32'h0000_0000);
         check(rd, {16'h0000, rows[i].mfr});
      end
      // Hold bit keeps the device off the bus though loading is done
      apb(1'b1, REG_CONTROL, 32'h0000_0002);
      repeat (3) @(posedge clock);
      check({31'h0, bus_connect}, 32'h0);
      apb(1'b1, REG_CONTROL, 32'h0000_0000);
      repeat (3) @(posedge clock);
      check({31'h0, bus_connect}, 32'h1);
      // Last row straps and header, connected and idle
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_007E);
      apb(1'b0, REG_HEADER, 32'h0000_0000);
      check(rd, {16'h0000, rows[7].hdr});
      // Reset in mid-run restores defaults and reloads
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      check({dac_shutdown, mic_highpass_en, microphone_gain_stage, config_done, bus_connect}, 32'h0C);
      nrst <= 1'b1;
      wait_load();
      apb(1'b0, 12'h100, 32'h0000_0000);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      end_of_test();
   end
endmodule // tb_top
